// File: include/ctl_cfg.svh
// Bit positions, register indices and reset values of the processor control bank
`ifndef CTL_CFG_SVH
`define CTL_CFG_SVH
`define MCW_PG_BIT 31
`define MCW_CD_BIT 30
`define MCW_NW_BIT 29
`define MCW_AM_BIT 18
`define MCW_WP_BIT 16
`define MCW_NE_BIT 5
`define MCW_ET_BIT 4
`define MCW_TS_BIT 3
`define MCW_EM_BIT 2
`define MCW_MP_BIT 1
`define MCW_PE_BIT 0
`define PDB_PCD_BIT 4
`define PDB_PWT_BIT 3
`define PDB_BASE_LSB 12
`define IDX_MCW 2'h0
`define IDX_RSV1 2'h1
`define IDX_FLA 2'h2
`define IDX_PDB 2'h3
`define TASK_SEL_RESET 16'h0000
`define TASK_BASE_RESET 32'h0000_0000
`define TASK_LIMIT_RESET 32'h0000_ffff
`define TASK_ATTR_RESET 12'h000
`define WORD_RESET 32'h0000_0000
`endif

// File: include/ctl_pkg.sv
// Types shared by the processor control bank and its helpers
package ctl_pkg;
  // Writable flags of the machine control word; the extension type bit is fixed
  typedef struct packed {
    logic pg, cd, nw, am, wp, ne, ts, em, mp, pe;
  } mcw_t;
  // Task pointer: visible selector plus the hidden descriptor copy
  typedef struct packed {
    logic [15:0] sel;
    logic [31:0] base;
    logic [31:0] limit;
    logic [11:0] attr;
  } task_ptr_t;
  // Whole state of the bank in one record
  typedef struct packed {
    mcw_t mcw;
    task_ptr_t task_ptr;
    logic [31:0] fla;
    logic [19:0] pdb_base;
    logic page_cache_disable, page_write_through;
    logic ign_meta, ign_sync;
    logic [31:0] rdata, phys;
    logic gp, nm, halt, fp_error_out_n;
  } bank_state_t;
endpackage : ctl_pkg

// File: include/ctl_flags_if.sv
// Flags and decisions passed between the control bank and its gating helpers
`timescale 1ns/10ps
`default_nettype none
interface ctl_flags_if;
  logic pe, pg, cd, nw, em, mp, ts, ne, ign_err;
  logic fp_instr, fp_wait, fp_err_pending;
  logic nm_req, fp_stop, fp_error_out_req, native_err;
  logic dir_pcd, dir_pwt, entry_pcd, entry_pwt;
  logic line_fill_en, write_alloc_en, hit_wb_inval, write_through_en;
  logic eff_dir_pcd, eff_dir_pwt, eff_page_pcd, eff_page_pwt;
  modport bank (output pe, pg, cd, nw, em, mp, ts, ne, ign_err, fp_instr, fp_wait, fp_err_pending,
                output dir_pcd, dir_pwt, entry_pcd, entry_pwt,
                input nm_req, fp_stop, fp_error_out_req, native_err, line_fill_en, write_alloc_en,
                input hit_wb_inval, write_through_en, eff_dir_pcd, eff_dir_pwt, eff_page_pcd, eff_page_pwt);
  modport fpu_gate (input em, mp, ts, ne, ign_err, fp_instr, fp_wait, fp_err_pending,
                    output nm_req, fp_stop, fp_error_out_req, native_err);
  modport cache_gate (input pg, cd, nw, dir_pcd, dir_pwt, entry_pcd, entry_pwt,
                      output line_fill_en, write_alloc_en, hit_wb_inval, write_through_en,
                      output eff_dir_pcd, eff_dir_pwt, eff_page_pcd, eff_page_pwt);
endinterface : ctl_flags_if
`default_nettype wire

// File: rtl/fpu_gate.sv
// Floating-point gating: device-not-available and error reporting decisions
`timescale 1ns/10ps
`default_nettype none
module fpu_gate (
  ctl_flags_if.fpu_gate flags
);
  // --------------------------------------------------------------------------
  // Fault and error decisions
  // --------------------------------------------------------------------------
  // Arithmetic ops fault on emulation or task switch; waits only when monitored
  always_comb begin
    flags.nm_req = (flags.fp_instr && (flags.em || flags.ts)) ||
                   (flags.fp_wait && flags.mp && flags.ts);
    // Native reporting raises the error inside the core
    flags.native_err = flags.ne && flags.fp_err_pending;
    // Legacy reporting: ignored while the ignore pin is asserted
    flags.fp_error_out_req = !flags.ne && !flags.ign_err && flags.fp_err_pending;
    // Stop just before the next waiting float or wait instruction
    flags.fp_stop = flags.fp_error_out_req && (flags.fp_instr || flags.fp_wait);
  end
endmodule : fpu_gate
`default_nettype wire

// File: rtl/cache_gate.sv
// Cache policy gating from the machine control word and directory flags
`timescale 1ns/10ps
`default_nettype none
module cache_gate (
  ctl_flags_if.cache_gate flags
);
  // --------------------------------------------------------------------------
  // Cache policy
  // --------------------------------------------------------------------------
  // Disabled caching: no fills, no allocation, hits write back and invalidate
  always_comb begin
    flags.line_fill_en = !flags.cd;
    flags.write_alloc_en = !flags.cd;
    flags.hit_wb_inval = flags.cd;
    flags.write_through_en = flags.nw;
    // Page-level flags are ignored while caching is off; directory flags also while paging is off
    flags.eff_dir_pcd = flags.dir_pcd && !flags.cd && flags.pg;
    flags.eff_dir_pwt = flags.dir_pwt && !flags.cd && flags.pg;
    flags.eff_page_pcd = flags.entry_pcd && !flags.cd;
    flags.eff_page_pwt = flags.entry_pwt && !flags.cd;
  end
endmodule : cache_gate
`default_nettype wire

// File: rtl/ctl_register_bank.sv
// Processor control register bank: control words, task pointer and fault gating
`timescale 1ns/10ps
`default_nettype none
`include "ctl_cfg.svh"

// How it works
// - Loading the task selector also copies base, limit and attributes from its descriptor.
// - Reset clears task base to zero and sets its limit to FFFF.
// - Directory base keeps upper twenty bits plus bits 4 and 3; other low bits read as zero.
// - A page fault records its linear address in the fault address register.
// - Protected mode refuses control writes from privilege one to three; reads allowed.
// - Setting paging while protection is off raises general protection and is refused.
// - With paging off, physical address equals linear address.
// - Cache disabled: no fills, no write allocation, write hits write back and invalidate.
// - Cache disabled: page-level cache and write-through flags are ignored.
// - Not-write-through flag enables hit write-throughs when set.
// - Alignment checks need mask flag, eflags flag, privilege three, protected or v86 mode.
// - Write-protect set blocks supervisor writes to read-only user pages.
// - Numeric error flag set selects native error reporting; else ignore pin discards errors.
// - Legacy reporting halts before next float or wait and asserts error pin.
// - Extension type bit always reads as one.
// - Every task switch sets the task-switched flag; float decode tests it.
// - Float instruction faults device-not-available when emulation or task-switched set.
// - Wait faults only when monitor and task-switched are both set.
// - Clear-task-switched instruction resets the task-switched flag.
// - Protection flag selects protected mode; paging needs protection and paging both.
// - Directory base holds page cache-disable at bit 4, write-through at bit 3.
module ctl_register_bank (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic cr_write_in,
  input wire logic cr_read_in,
  input wire logic [1:0] cr_index_in,
  input wire logic [31:0] cr_wdata_in,
  output logic [31:0] cr_rdata_out,
  input wire logic [1:0] current_privilege_in,
  input wire logic alignment_check_flag_in,
  input wire logic load_task_pointer_instr_in,
  input wire logic [15:0] task_sel_in,
  input wire logic [31:0] task_desc_base_in,
  input wire logic [31:0] task_desc_limit_in,
  input wire logic [11:0] task_desc_attr_in,
  output logic [15:0] task_sel_out,
  output logic [31:0] task_base_out,
  output logic [31:0] task_limit_out,
  output logic [11:0] task_attr_out,
  input wire logic task_switch_in,
  input wire logic clear_task_switched_instr_in,
  input wire logic page_fault_in,
  input wire logic [31:0] fault_addr_in,
  input wire logic [31:0] linear_addr_in,
  input wire logic [31:0] translated_addr_in,
  output logic [31:0] phys_addr_out,
  output logic protected_mode_out,
  output logic paging_active_out,
  output logic [19:0] dir_base_out,
  input wire logic entry_pcd_in,
  input wire logic entry_pwt_in,
  output logic line_fill_en_out,
  output logic write_alloc_en_out,
  output logic hit_wb_inval_out,
  output logic write_through_en_out,
  output logic dir_cache_disable_out,
  output logic dir_write_through_out,
  output logic page_cache_disable_out,
  output logic page_write_through_out,
  output logic align_check_en_out,
  input wire logic sup_write_ro_user_in,
  output logic write_protect_block_out,
  input wire logic fp_instr_in,
  input wire logic fp_wait_instr_in,
  input wire logic fp_err_pending_in,
  input wire logic ignore_fp_error_n_in,
  output logic native_fp_error_out,
  output logic fp_halt_out,
  output logic fp_error_n_out,
  output logic device_not_available_fault_out,
  output logic general_protection_fault_out
);

  // --------------------------------------------------------------------------
  // Word packing helpers
  // --------------------------------------------------------------------------
  // Control word as software sees it; extension type is wired high
  function automatic logic [31:0] mcw_word(input ctl_pkg::mcw_t m);
    logic [31:0] w;
    w = `WORD_RESET;
    w[`MCW_PG_BIT] = m.pg;
    w[`MCW_CD_BIT] = m.cd;
    w[`MCW_NW_BIT] = m.nw;
    w[`MCW_AM_BIT] = m.am;
    w[`MCW_WP_BIT] = m.wp;
    w[`MCW_NE_BIT] = m.ne;
    w[`MCW_ET_BIT] = 1'b1;
    w[`MCW_TS_BIT] = m.ts;
    w[`MCW_EM_BIT] = m.em;
    w[`MCW_MP_BIT] = m.mp;
    w[`MCW_PE_BIT] = m.pe;
    return w;
  endfunction : mcw_word

  // Directory base word; unkept low bits read as zero
  function automatic logic [31:0] pdb_word(input logic [19:0] base, input logic page_cache_disable, input logic page_write_through);
    logic [31:0] w;
    w = {base, 12'h000};
    w[`PDB_PCD_BIT] = page_cache_disable;
    w[`PDB_PWT_BIT] = page_write_through;
    return w;
  endfunction : pdb_word

  // --------------------------------------------------------------------------
  // State and helper instances
  // --------------------------------------------------------------------------
  ctl_pkg::bank_state_t st_ff;
  ctl_pkg::bank_state_t nxt_st;
  ctl_pkg::mcw_t wr_mcw;
  ctl_flags_if flags ();
  logic priv_bad;
  logic wr_mcw_req;
  logic pg_no_pe;
  logic refuse;
  logic paging_on;

  fpu_gate u_fpu_gate (
    .flags (flags.fpu_gate)
  );

  cache_gate u_cache_gate (
    .flags (flags.cache_gate)
  );

  // Flags toward the helpers come from registered state, except the instruction, pending-error and entry inputs
  assign flags.pe = st_ff.mcw.pe;
  assign flags.pg = st_ff.mcw.pg;
  assign flags.cd = st_ff.mcw.cd;
  assign flags.nw = st_ff.mcw.nw;
  assign flags.em = st_ff.mcw.em;
  assign flags.mp = st_ff.mcw.mp;
  assign flags.ts = st_ff.mcw.ts;
  assign flags.ne = st_ff.mcw.ne;
  assign flags.ign_err = !st_ff.ign_sync;  // Pin is active low
  assign flags.fp_instr = fp_instr_in;
  assign flags.fp_wait = fp_wait_instr_in;
  assign flags.fp_err_pending = fp_err_pending_in;
  assign flags.dir_pcd = st_ff.page_cache_disable;
  assign flags.dir_pwt = st_ff.page_write_through;
  assign flags.entry_pcd = entry_pcd_in;
  assign flags.entry_pwt = entry_pwt_in;

  // --------------------------------------------------------------------------
  // Write qualification
  // --------------------------------------------------------------------------
  // Privileged loads from ring 1..3 in protected mode are refused with a fault
  assign priv_bad = st_ff.mcw.pe && (current_privilege_in != 2'h0);
  assign wr_mcw_req = cr_write_in && (cr_index_in == `IDX_MCW);
  assign pg_no_pe = cr_wdata_in[`MCW_PG_BIT] && !cr_wdata_in[`MCW_PE_BIT];
  assign refuse = priv_bad || (wr_mcw_req && pg_no_pe);
  // Paging translates only when both protection and paging are on
  assign paging_on = st_ff.mcw.pg && st_ff.mcw.pe;

  // Unpack a written control word; the extension type bit is dropped
  always_comb begin
    wr_mcw.pg = cr_wdata_in[`MCW_PG_BIT];
    wr_mcw.cd = cr_wdata_in[`MCW_CD_BIT];
    wr_mcw.nw = cr_wdata_in[`MCW_NW_BIT];
    wr_mcw.am = cr_wdata_in[`MCW_AM_BIT];
    wr_mcw.wp = cr_wdata_in[`MCW_WP_BIT];
    wr_mcw.ne = cr_wdata_in[`MCW_NE_BIT];
    wr_mcw.ts = cr_wdata_in[`MCW_TS_BIT];
    wr_mcw.em = cr_wdata_in[`MCW_EM_BIT];
    wr_mcw.mp = cr_wdata_in[`MCW_MP_BIT];
    wr_mcw.pe = cr_wdata_in[`MCW_PE_BIT];
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  // Hardware events are applied after software writes so that they win
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ign_meta = ignore_fp_error_n_in;
    nxt_st.ign_sync = st_ff.ign_meta;
    nxt_st.gp = (cr_write_in || load_task_pointer_instr_in || clear_task_switched_instr_in) && refuse;
    nxt_st.nm = flags.nm_req;
    nxt_st.halt = flags.fp_stop;
    nxt_st.fp_error_out_n = !flags.fp_error_out_req;
    nxt_st.phys = paging_on ? translated_addr_in : linear_addr_in;
    if (cr_write_in && !refuse) begin
      unique case (cr_index_in)
        `IDX_MCW: nxt_st.mcw = wr_mcw;
        `IDX_RSV1: nxt_st.fla = st_ff.fla;  // Reserved register has no storage
        `IDX_FLA: nxt_st.fla = cr_wdata_in;
        `IDX_PDB: begin
          nxt_st.pdb_base = cr_wdata_in[31:`PDB_BASE_LSB];
          nxt_st.page_cache_disable = cr_wdata_in[`PDB_PCD_BIT];
          nxt_st.page_write_through = cr_wdata_in[`PDB_PWT_BIT];
        end
      endcase
    end
    // Selector load pulls the hidden fields from the table descriptor
    if (load_task_pointer_instr_in && !priv_bad) begin
      nxt_st.task_ptr.sel = task_sel_in;
      nxt_st.task_ptr.base = task_desc_base_in;
      nxt_st.task_ptr.limit = task_desc_limit_in;
      nxt_st.task_ptr.attr = task_desc_attr_in;
    end
    if (clear_task_switched_instr_in && !priv_bad) begin
      nxt_st.mcw.ts = 1'b0;
    end
    // A switch in the same cycle as a clear leaves the flag set
    if (task_switch_in) begin
      nxt_st.mcw.ts = 1'b1;
    end
    // The faulting address beats a software write in the same cycle
    if (page_fault_in) begin
      nxt_st.fla = fault_addr_in;
    end
    if (cr_read_in) begin
      unique case (cr_index_in)
        `IDX_MCW: nxt_st.rdata = mcw_word(st_ff.mcw);
        `IDX_RSV1: nxt_st.rdata = `WORD_RESET;
        `IDX_FLA: nxt_st.rdata = st_ff.fla;
        `IDX_PDB: nxt_st.rdata = pdb_word(st_ff.pdb_base, st_ff.page_cache_disable, st_ff.page_write_through);
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  // Reset loads constants only; the synchroniser resets to not-ignoring
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0;
      st_ff.task_ptr.sel <= `TASK_SEL_RESET;
      st_ff.task_ptr.base <= `TASK_BASE_RESET;
      st_ff.task_ptr.limit <= `TASK_LIMIT_RESET;
      st_ff.task_ptr.attr <= `TASK_ATTR_RESET;
      st_ff.ign_meta <= 1'b1;
      st_ff.ign_sync <= 1'b1;
      st_ff.fp_error_out_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign cr_rdata_out = st_ff.rdata;
  assign task_sel_out = st_ff.task_ptr.sel;
  assign task_base_out = st_ff.task_ptr.base;
  assign task_limit_out = st_ff.task_ptr.limit;
  assign task_attr_out = st_ff.task_ptr.attr;
  assign phys_addr_out = st_ff.phys;
  assign protected_mode_out = st_ff.mcw.pe;
  assign paging_active_out = paging_on;
  assign dir_base_out = st_ff.pdb_base;
  assign line_fill_en_out = flags.line_fill_en;
  assign write_alloc_en_out = flags.write_alloc_en;
  assign hit_wb_inval_out = flags.hit_wb_inval;
  assign write_through_en_out = flags.write_through_en;
  assign dir_cache_disable_out = flags.eff_dir_pcd;
  assign dir_write_through_out = flags.eff_dir_pwt;
  assign page_cache_disable_out = flags.eff_page_pcd;
  assign page_write_through_out = flags.eff_page_pwt;
  // Eflags bit only counts in user ring of protected or v86 mode
  assign align_check_en_out = st_ff.mcw.am && alignment_check_flag_in &&
                              (current_privilege_in == 2'h3) && st_ff.mcw.pe;
  // Copy-on-write relies on this block of supervisor writes
  assign write_protect_block_out = st_ff.mcw.wp && sup_write_ro_user_in;
  assign native_fp_error_out = flags.native_err;
  assign fp_halt_out = st_ff.halt;
  assign fp_error_n_out = st_ff.fp_error_out_n;
  assign device_not_available_fault_out = st_ff.nm;
  assign general_protection_fault_out = st_ff.gp;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  AST_TASK_LOAD: assert property (load_task_pointer_instr_in && !priv_bad |=>
    task_base_out == $past(task_desc_base_in) && task_sel_out == $past(task_sel_in))
    else $error("Task descriptor not copied on selector load");
  AST_RESET_TASK: assert property ($past(rst_in) |->
    task_base_out == `TASK_BASE_RESET && task_limit_out == `TASK_LIMIT_RESET)
    else $error("Task pointer reset values wrong");
  AST_PDB_ALIGN: assert property (cr_read_in && cr_index_in == `IDX_PDB |=>
    cr_rdata_out[11:5] == 7'h00 && cr_rdata_out[2:0] == 3'h0)
    else $error("Directory base low bits not zero");
  AST_FAULT_ADDR: assert property (page_fault_in ##1 (cr_read_in && cr_index_in == `IDX_FLA) |=>
    cr_rdata_out == $past(fault_addr_in, 2))
    else $error("Fault address not recorded");
  AST_PRIV_REFUSE: assert property (cr_write_in && priv_bad && !task_switch_in |=>
    general_protection_fault_out && $stable(st_ff.mcw) && $stable(st_ff.pdb_base))
    else $error("Unprivileged control write not refused");
  AST_PG_NO_PE: assert property (wr_mcw_req && pg_no_pe |=>
    general_protection_fault_out && $stable(st_ff.mcw.pg) && $stable(st_ff.mcw.pe))
    else $error("Paging without protection not faulted");
  AST_PASSTHRU: assert property (!paging_on |=> phys_addr_out == $past(linear_addr_in))
    else $error("Linear address not passed through");
  AST_CD_POLICY: assert property (st_ff.mcw.cd |->
    !line_fill_en_out && !write_alloc_en_out && hit_wb_inval_out && !page_cache_disable_out)
    else $error("Cache disable policy wrong");
  AST_ET_ONE: assert property (cr_read_in && cr_index_in == `IDX_MCW |=> cr_rdata_out[`MCW_ET_BIT])
    else $error("Extension type bit not one");
  AST_TS_SET: assert property (task_switch_in |=> st_ff.mcw.ts)
    else $error("Task switch did not set flag");
  AST_NM_FP: assert property (fp_instr_in && (st_ff.mcw.em || st_ff.mcw.ts) |=>
    device_not_available_fault_out)
    else $error("Float instruction did not fault");
  AST_NM_WAIT: assert property (fp_wait_instr_in && !fp_instr_in |=>
    device_not_available_fault_out == ($past(st_ff.mcw.mp) && $past(st_ff.mcw.ts)))
    else $error("Wait fault decision wrong");
  AST_CLEAR_TASK_SWITCHED_INSTR: assert property (clear_task_switched_instr_in && !priv_bad && !task_switch_in |=>
    !st_ff.mcw.ts)
    else $error("Clear task switched ignored");
  AST_FP_ERROR_OUT: assert property (!st_ff.mcw.ne && st_ff.ign_sync && fp_err_pending_in |=>
    !fp_error_n_out)
    else $error("Error pin not asserted");
  AST_RSVD: assert property (cr_read_in && cr_index_in == `IDX_RSV1 |=> cr_rdata_out == `WORD_RESET)
    else $error("Reserved register not zero");
  AST_FP_EXEC: assert property (fp_instr_in && !st_ff.mcw.em && !st_ff.mcw.ts |=>
    !device_not_available_fault_out)
    else $error("Float instruction faulted with both flags clear");
  AST_HALT: assert property (!st_ff.mcw.ne && st_ff.ign_sync && fp_err_pending_in && fp_wait_instr_in |=>
    fp_halt_out)
    else $error("Waiting instruction not halted on pending error");
  AST_NATIVE_QUIET: assert property (st_ff.mcw.ne |=> fp_error_n_out)
    else $error("Error pin asserted under native reporting");
  AST_ALIGN_USER: assert property (current_privilege_in != 2'h3 |-> !align_check_en_out)
    else $error("Alignment check outside user level");

  COV_TASK_LOAD: cover property (load_task_pointer_instr_in && !priv_bad);
  COV_SWITCH_NM: cover property (task_switch_in ##1 fp_instr_in ##1 device_not_available_fault_out);
  COV_GP: cover property (general_protection_fault_out);
  COV_PAGING: cover property (wr_mcw_req && !refuse && cr_wdata_in[`MCW_PG_BIT] ##1 paging_active_out);

endmodule : ctl_register_bank
`default_nettype wire

// File: testbench/processor_control_register_bank_tb.sv
// Self-checking bench for the processor control register bank
`timescale 1ns/10ps
`default_nettype none
module processor_control_register_bank_tb;
  logic sys_clk_in = 1'b0, rst_in = 1'b1, cr_write_in = 1'b0, cr_read_in = 1'b0, alignment_check_flag_in = 1'b0;
  logic load_task_pointer_instr_in = 1'b0, task_switch_in = 1'b0, clear_task_switched_instr_in = 1'b0;
  logic page_fault_in = 1'b0, entry_pcd_in = 1'b1, entry_pwt_in = 1'b1, sup_write_ro_user_in = 1'b0;
  logic fp_instr_in = 1'b0, fp_wait_instr_in = 1'b0, fp_err_pending_in = 1'b0, ignore_fp_error_n_in = 1'b1;
  logic [1:0] cr_index_in = 2'h0, current_privilege_in = 2'h0;
  logic [31:0] cr_wdata_in = 32'h0, task_desc_base_in = 32'h0, task_desc_limit_in = 32'h0, fault_addr_in = 32'h0;
  logic [31:0] linear_addr_in = 32'h1357_9bdf, translated_addr_in = 32'h2468_ace0;
  logic [15:0] task_sel_in = 16'h0;
  logic [11:0] task_desc_attr_in = 12'h0;
  logic [31:0] cr_rdata_out, task_base_out, task_limit_out, phys_addr_out;
  logic [15:0] task_sel_out;
  logic [11:0] task_attr_out;
  logic [19:0] dir_base_out;
  logic protected_mode_out, paging_active_out, line_fill_en_out, write_alloc_en_out, hit_wb_inval_out;
  logic write_through_en_out, dir_cache_disable_out, dir_write_through_out, page_cache_disable_out;
  logic page_write_through_out, align_check_en_out, write_protect_block_out, native_fp_error_out;
  logic fp_halt_out, fp_error_n_out, device_not_available_fault_out, general_protection_fault_out;
  int fails = 0, samples_checked = 0;
  logic gp, nm, halt;

  // ---------------------------------------------------------------
  // Clock, design and shared tasks
  // ---------------------------------------------------------------
  always #25 sys_clk_in = ~sys_clk_in; // 20 MHz
  ctl_register_bank i_ctl_register_bank (.*);

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Each request is held across exactly one sampling edge, then a quiet cycle
  task automatic wr(input logic [1:0] idx, input logic [31:0] d);
    cr_index_in = idx;
    cr_wdata_in = d;
    cr_write_in = 1'b1;
    @(negedge sys_clk_in) gp = general_protection_fault_out;
    cr_write_in = 1'b0;
    @(negedge sys_clk_in);
  endtask : wr
  task automatic rd(input logic [1:0] idx, input logic [31:0] exp);
    cr_index_in = idx;
    cr_read_in = 1'b1;
    @(negedge sys_clk_in) cr_read_in = 1'b0;
    chk("rdata", cr_rdata_out, exp);
    @(negedge sys_clk_in);
  endtask : rd
  task automatic fp(input logic f, input logic w);
    fp_instr_in = f;
    fp_wait_instr_in = w;
    @(negedge sys_clk_in) nm = device_not_available_fault_out;
    halt = fp_halt_out;
    fp_instr_in = 1'b0;
    fp_wait_instr_in = 1'b0;
    @(negedge sys_clk_in);
  endtask : fp

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_mode;
    chk("task_base", task_base_out, 32'h0);
    chk("task_limit", task_limit_out, 32'h0000_ffff);
    rd(2'h0, 32'h0000_0010);
    chk("phys", phys_addr_out, linear_addr_in);
    wr(2'h0, 32'h8000_0000);
    chk("gp", gp, 1'b1);
    rd(2'h0, 32'h0000_0010);
    wr(2'h0, 32'h8000_0001); // Protection and paging set together
    chk("paging", paging_active_out, 1'b1);
    chk("phys", phys_addr_out, translated_addr_in);
    current_privilege_in = 2'h3; // A user-level move to the control word must bounce
    wr(2'h0, 32'h0000_0000);
    chk("gp", gp, 1'b1);
    rd(2'h0, 32'h8000_0011);
    current_privilege_in = 2'h0;
    $display("t_mode done");
  endtask : t_mode
  task automatic t_regs;
    task_sel_in = 16'h0028;
    task_desc_base_in = 32'h0001_2340;
    task_desc_limit_in = 32'h0000_0067;
    task_desc_attr_in = 12'h089;
    load_task_pointer_instr_in = 1'b1;
    @(negedge sys_clk_in) load_task_pointer_instr_in = 1'b0;
    chk("task", {task_sel_out, task_base_out[15:0]}, 32'h0028_2340);
    chk("task_attr", {task_limit_out[19:0], task_attr_out}, 32'h0006_7089);
    wr(2'h3, 32'hfedc_bfff);
    rd(2'h3, 32'hfedc_b018);
    chk("dir_base", dir_base_out, 20'hfedcb);
    wr(2'h1, 32'hffff_ffff);
    rd(2'h1, 32'h0);
    fault_addr_in = 32'h0bad_f00c;
    page_fault_in = 1'b1;
    @(negedge sys_clk_in) page_fault_in = 1'b0;
    rd(2'h2, 32'h0bad_f00c);
    wr(2'h0, 32'h6000_0001); // Cache off with write-through cycles on
    chk("cache", {line_fill_en_out, hit_wb_inval_out, write_through_en_out}, 3'h3);
    chk("page_pcd", page_cache_disable_out, 1'b0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_fpu;
    for (int i = 0; i < 8; i++) begin
      wr(2'h0, {28'h0, i[0], i[2:1], 1'b1}); // i[2]=emulation, i[1]=monitor, i[0]=task switched
      fp(1'b1, 1'b0);
      chk("nm_fp", nm, i[2] | i[0]);
      fp(1'b0, 1'b1);
      chk("nm_wait", nm, i[1] & i[0]);
    end
    wr(2'h0, 32'h0000_0001);
    task_switch_in = 1'b1;
    @(negedge sys_clk_in) task_switch_in = 1'b0;
    fp(1'b1, 1'b0);
    chk("nm_switch", nm, 1'b1);
    clear_task_switched_instr_in = 1'b1;
    @(negedge sys_clk_in) clear_task_switched_instr_in = 1'b0;
    fp(1'b1, 1'b0);
    chk("nm_clear_task_switched_instr", nm, 1'b0);
    $display("t_fpu done");
  endtask : t_fpu
  // Page flags, alignment, write protect and float error reporting
  task automatic t_misc;
    wr(2'h0, 32'h8005_0001);
    chk("pmode", protected_mode_out, 1'b1);
    chk("dir_flags", {dir_cache_disable_out, dir_write_through_out}, 2'h3);
    chk("page_flags", {page_cache_disable_out, page_write_through_out}, 2'h3);
    chk("wr_alloc", write_alloc_en_out, 1'b1);
    alignment_check_flag_in = 1'b1;
    current_privilege_in = 2'h3;
    sup_write_ro_user_in = 1'b1;
    @(negedge sys_clk_in);
    chk("align_user", align_check_en_out, 1'b1);
    chk("wp_block", write_protect_block_out, 1'b1);
    current_privilege_in = 2'h0;
    @(negedge sys_clk_in);
    chk("align_sup", align_check_en_out, 1'b0);
    fp_err_pending_in = 1'b1;
    fp(1'b0, 1'b1);
    chk("halt", halt, 1'b1);
    chk("fp_error_out", fp_error_n_out, 1'b0);
    chk("native_off", native_fp_error_out, 1'b0);
    ignore_fp_error_n_in = 1'b0; // Two synchroniser stages plus the output register
    repeat (3) @(negedge sys_clk_in);
    chk("fp_error_out_ignored", fp_error_n_out, 1'b1);
    ignore_fp_error_n_in = 1'b1;
    wr(2'h0, 32'h0000_0021);
    chk("native_on", native_fp_error_out, 1'b1);
    chk("wp_off", write_protect_block_out, 1'b0);
    fp_err_pending_in = 1'b0;
    sup_write_ro_user_in = 1'b0;
    alignment_check_flag_in = 1'b0;
    $display("t_misc done");
  endtask : t_misc

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  // Watchdog: the whole run is far shorter than this
  initial begin
    #2000000;
    fails++;
    test_done();
  end
  initial begin
    repeat (16) @(negedge sys_clk_in);
    rst_in = 1'b0;
    @(negedge sys_clk_in);
    t_mode();
    t_regs();
    t_fpu();
    t_misc();
    test_done();
  end
endmodule : processor_control_register_bank_tb
`default_nettype wire
